/* common/serial_port_pkg.sv */
// shared constants and carriers for the serial port register set
package serial_port_pkg;

    // ************************************************************
    // register map (word aligned byte addresses)
    // ************************************************************
    localparam int ADDR_W = 5;
    localparam logic [4:0] TXC_ADDR = 5'h00;
    localparam logic [4:0] RXC_ADDR = 5'h04;
    localparam logic [4:0] BAUD_ADDR = 5'h08;
    localparam logic [4:0] RXD_ADDR = 5'h0c;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int TXC_CLKSRC = 7;
    localparam int TXC_TX9 = 6;
    localparam int TXC_TRANSMIT_ENABLE_BIT = 5;
    localparam int TXC_SYNC = 4;
    localparam int TXC_BREAK = 3;
    localparam int TXC_HIGH = 2;
    localparam int TXC_TRANSMIT_NINTH_BIT = 0;
    localparam int RXC_PEN = 7;
    localparam int RXC_RX9 = 6;
    localparam int RXC_SINGLE = 5;
    localparam int RXC_CONT = 4;
    localparam int RXC_ADDR_DET = 3;
    localparam int BAUD_POL = 4;
    localparam int BAUD_WIDE = 3;
    localparam int BAUD_WAKE = 1;
    localparam int BAUD_ABD = 0;

    // ************************************************************
    // reset values and writable masks
    // ************************************************************
    localparam logic [7:0] TXC_RESET = 8'h00;
    localparam logic [7:0] TXC_WMASK = 8'hfd;
    localparam logic [7:0] RXC_RESET = 8'h00;
    localparam logic [7:0] RXC_WMASK = 8'hf8;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam logic [7:0] BAUD_WMASK = 8'h1b;
    localparam int RX_FIFO_DEPTH = 2;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic framing_error_flag;
        logic [8:0] data;
    } rx_char_t;

    typedef struct packed {
        logic shift_empty;
        logic break_done;
        logic rx_start;
        logic rx_valid;
        rx_char_t rx_char;
        logic rx_edge;
        logic abd_done;
        logic abd_overflow;
    } eng_status_t;

    typedef struct packed {
        logic port_enable;
        logic sync_mode;
        logic clock_master;
        logic tx_enable;
        logic tx_nine;
        logic tx_ninth;
        logic send_break;
        logic high_baud;
        logic wide_gen;
        logic polarity;
        logic rx_enable;
        logic rx_nine;
        logic wake_wait;
        logic autobaud_run;
    } port_cfg_t;

endpackage

/* rtl/rx_char_fifo.sv */
// small receive character fifo, first word always presented
`timescale 1ns/1ps
`default_nettype none
module rx_char_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] din,
    input wire logic pop,
    output logic [WIDTH-1:0] dout,
    output logic empty,
    output logic full
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] rd_ff;
    logic [PW-1:0] wr_ff;
    logic [PW:0] cnt_ff;
    logic do_push;
    logic do_pop;

    assign empty = (cnt_ff == '0);
    assign full = (cnt_ff == (PW+1)'(DEPTH));
    assign dout = mem[rd_ff];
    assign do_push = push && !full;
    assign do_pop = pop && !empty;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ff] <= din;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || flush) begin
            rd_ff <= '0;
            wr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (do_push) begin
                wr_ff <= (wr_ff == PW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (do_pop) begin
                rd_ff <= (rd_ff == PW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end
    end
endmodule
`default_nettype wire

/* rtl/serial_port_regs.sv */
// control and status registers of the serial port, avalon-mm slave
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - clock source bit: sync mode master when set, slave when clear; ignored async.
// - transmit word-length bit picks 9-bit or 8-bit transmission.
// - transmitter runs only while transmit enable is set.
// - mode bit chooses synchronous or asynchronous operation; other fields follow it.
// - break request sends break async, hardware clears it when done; ignored sync.
// - high baud bit selects fast divider async only.
// - shift-empty flag is read-only, shows transmit shifter empty, resets to 1.
// - transmit ninth bit supplies bit nine of each 9-bit character.
// - receive word-length bit picks 9-bit or 8-bit reception.
// - single receive in sync master takes one character then self-clears.
// - continuous receive enables receiver; in sync it overrides single receive.
// - receive ninth bit shows bit nine of the top unread character.
// - port disable clears framing error; clearing continuous receive does not.
// - receive idle flag low from start bit until character done; resets 1.
// - polarity bit inverts data async or picks clock edge sync.
// - wide generator bit selects 16-bit or 8-bit baud generator.
// - wake-up waits for falling edge, then flags receive and self-clears.
// - auto-baud enable starts detection and clears itself when done.
module serial_port_regs (
    input wire logic clk,
    input wire logic srst,
    input wire logic [serial_port_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire serial_port_pkg::eng_status_t eng_in,
    output serial_port_pkg::port_cfg_t cfg_out,
    output logic rx_irq
);
    logic [7:0] txc_ff;
    logic [7:0] rxc_ff;
    logic [7:0] baud_ff;
    logic shift_empty_flag_ff;
    logic receive_idle_flag_ff;
    logic autobaud_overflow_flag_ff;
    logic overrun_error_flag_ff;
    logic wake_ff;
    logic [31:0] nxt_rdata;
    serial_port_pkg::port_cfg_t nxt_cfg;
    serial_port_pkg::rx_char_t top_char;
    logic fifo_empty;
    logic fifo_full;
    logic req;
    logic acc;
    logic wr_txc;
    logic wr_rxc;
    logic wr_baud;
    logic pop;
    logic pen;
    logic is_async;
    logic accept;
    logic keep_char;

    // ************************************************************
    // bus handshake: one wait cycle, access commits when wait is low
    // ************************************************************
    assign req = avs_read || avs_write;
    assign acc = req && !avs_waitrequest;
    assign wr_txc = acc && avs_write && avs_address == serial_port_pkg::TXC_ADDR;
    assign wr_rxc = acc && avs_write && avs_address == serial_port_pkg::RXC_ADDR;
    assign wr_baud = acc && avs_write && avs_address == serial_port_pkg::BAUD_ADDR;
    assign pop = acc && avs_read && avs_address == serial_port_pkg::RXD_ADDR;

    always_ff @(posedge clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(req && avs_waitrequest);
        end
    end

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (avs_address)
            serial_port_pkg::TXC_ADDR: begin
                nxt_rdata[7:0] = {txc_ff[7:2], shift_empty_flag_ff, txc_ff[0]};
            end
            serial_port_pkg::RXC_ADDR: begin
                nxt_rdata[7:0] = {rxc_ff[7:3], top_char.framing_error_flag && !fifo_empty, overrun_error_flag_ff,
                                  top_char.data[8] && !fifo_empty};
            end
            serial_port_pkg::BAUD_ADDR: begin
                nxt_rdata[7:0] = {autobaud_overflow_flag_ff, receive_idle_flag_ff, 1'b0, baud_ff[4:3], 1'b0,
                                  baud_ff[1:0]};
            end
            serial_port_pkg::RXD_ADDR: begin
                // an empty fifo reads zero rather than a stale slot
                nxt_rdata[7:0] = fifo_empty ? 8'h00 : top_char.data[7:0];
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (req && avs_waitrequest) begin
            avs_readdata <= nxt_rdata;
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    assign pen = rxc_ff[serial_port_pkg::RXC_PEN];
    assign is_async = !txc_ff[serial_port_pkg::TXC_SYNC];

    always_ff @(posedge clk) begin
        if (srst) begin
            txc_ff <= serial_port_pkg::TXC_RESET;
        end else if (wr_txc) begin
            // a software write in the same cycle as break end wins
            txc_ff <= avs_writedata[7:0] & serial_port_pkg::TXC_WMASK;
        end else if (eng_in.break_done) begin
            txc_ff[serial_port_pkg::TXC_BREAK] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rxc_ff <= serial_port_pkg::RXC_RESET;
        end else if (wr_rxc) begin
            rxc_ff <= avs_writedata[7:0] & serial_port_pkg::RXC_WMASK;
        end else if (accept && !is_async && cfg_out.clock_master
                     && !rxc_ff[serial_port_pkg::RXC_CONT]) begin
            rxc_ff[serial_port_pkg::RXC_SINGLE] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            baud_ff <= serial_port_pkg::BAUD_RESET;
        end else if (wr_baud) begin
            baud_ff <= avs_writedata[7:0] & serial_port_pkg::BAUD_WMASK;
        end else begin
            if (eng_in.rx_edge && is_async && pen) begin
                baud_ff[serial_port_pkg::BAUD_WAKE] <= 1'b0;
            end
            if (eng_in.abd_done) begin
                baud_ff[serial_port_pkg::BAUD_ABD] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // status flags
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_empty_flag_ff <= 1'b1;
        end else begin
            shift_empty_flag_ff <= eng_in.shift_empty || !pen;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !pen || !is_async) begin
            receive_idle_flag_ff <= 1'b1;
        end else if (eng_in.rx_start) begin
            receive_idle_flag_ff <= 1'b0;
        end else if (eng_in.rx_valid) begin
            receive_idle_flag_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !pen) begin
            autobaud_overflow_flag_ff <= 1'b0;
        end else if (eng_in.abd_overflow && is_async) begin
            autobaud_overflow_flag_ff <= 1'b1;
        end else if (wr_baud && avs_writedata[serial_port_pkg::BAUD_ABD]) begin
            autobaud_overflow_flag_ff <= 1'b0;
        end
    end

    // in async 9-bit mode, address detect drops characters whose ninth bit is clear
    assign keep_char = !(is_async && rxc_ff[serial_port_pkg::RXC_RX9]
                         && rxc_ff[serial_port_pkg::RXC_ADDR_DET]
                         && !eng_in.rx_char.data[8]);
    assign accept = eng_in.rx_valid && cfg_out.rx_enable && keep_char;

    always_ff @(posedge clk) begin
        if (srst || !pen || !rxc_ff[serial_port_pkg::RXC_CONT]) begin
            overrun_error_flag_ff <= 1'b0;
        end else if (accept && fifo_full) begin
            overrun_error_flag_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !pen) begin
            wake_ff <= 1'b0;
        end else if (eng_in.rx_edge && is_async && baud_ff[serial_port_pkg::BAUD_WAKE]) begin
            wake_ff <= 1'b1;
        end else if (pop) begin
            wake_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_irq <= 1'b0;
        end else begin
            rx_irq <= !fifo_empty || wake_ff;
        end
    end

    // ************************************************************
    // receive fifo; port disable flushes it with its framing bits
    // ************************************************************
    rx_char_fifo #(
        .WIDTH($bits(serial_port_pkg::rx_char_t)),
        .DEPTH(serial_port_pkg::RX_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .flush(!pen),
        .push(accept),
        .din(eng_in.rx_char),
        .pop(pop),
        .dout(top_char),
        .empty(fifo_empty),
        .full(fifo_full)
    );

    // ************************************************************
    // effective configuration toward the shift engines
    // ************************************************************
    always_comb begin
        nxt_cfg.port_enable = pen;
        nxt_cfg.sync_mode = !is_async;
        nxt_cfg.clock_master = !is_async && txc_ff[serial_port_pkg::TXC_CLKSRC];
        nxt_cfg.tx_enable = pen && txc_ff[serial_port_pkg::TXC_TRANSMIT_ENABLE_BIT];
        nxt_cfg.tx_nine = txc_ff[serial_port_pkg::TXC_TX9];
        nxt_cfg.tx_ninth = txc_ff[serial_port_pkg::TXC_TRANSMIT_NINTH_BIT];
        nxt_cfg.send_break = is_async && txc_ff[serial_port_pkg::TXC_BREAK];
        nxt_cfg.high_baud = is_async && txc_ff[serial_port_pkg::TXC_HIGH];
        nxt_cfg.wide_gen = baud_ff[serial_port_pkg::BAUD_WIDE];
        nxt_cfg.polarity = baud_ff[serial_port_pkg::BAUD_POL];
        // continuous wins over single; single only counts as sync master
        nxt_cfg.rx_enable = pen && !overrun_error_flag_ff && (rxc_ff[serial_port_pkg::RXC_CONT]
            || (!is_async && txc_ff[serial_port_pkg::TXC_CLKSRC]
                && rxc_ff[serial_port_pkg::RXC_SINGLE]));
        nxt_cfg.rx_nine = rxc_ff[serial_port_pkg::RXC_RX9];
        nxt_cfg.wake_wait = is_async && baud_ff[serial_port_pkg::BAUD_WAKE];
        nxt_cfg.autobaud_run = is_async && baud_ff[serial_port_pkg::BAUD_ABD];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_out <= '0;
        end else begin
            cfg_out <= nxt_cfg;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_master_sync;
        cfg_out.clock_master |-> cfg_out.sync_mode;
    endproperty
    a_master_sync: assert property (p_master_sync) else $error("master outside sync");

    property p_tx_gate;
        !txc_ff[serial_port_pkg::TXC_TRANSMIT_ENABLE_BIT] |=> !cfg_out.tx_enable;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("transmitter on while disabled");

    property p_break_clear;
        eng_in.break_done && !wr_txc |=> !txc_ff[serial_port_pkg::TXC_BREAK] ##1 !cfg_out.send_break;
    endproperty
    a_break_clear: assert property (p_break_clear) else $error("break request not cleared");

    property p_single_clear;
        accept && !is_async && cfg_out.clock_master && !rxc_ff[serial_port_pkg::RXC_CONT]
            && !wr_rxc |=> !rxc_ff[serial_port_pkg::RXC_SINGLE];
    endproperty
    a_single_clear: assert property (p_single_clear) else $error("single receive stuck");

    property p_overrun;
        accept && fifo_full && pen && rxc_ff[serial_port_pkg::RXC_CONT] && !wr_rxc
            |=> overrun_error_flag_ff ##1 !cfg_out.rx_enable;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_disable_flush;
        !pen |=> fifo_empty && !overrun_error_flag_ff;
    endproperty
    a_disable_flush: assert property (p_disable_flush) else $error("disable left errors");

    property p_baud_zero;
        avs_read && !avs_waitrequest && $past(avs_address) == serial_port_pkg::BAUD_ADDR
            |-> avs_readdata[5] == 1'b0 && avs_readdata[2] == 1'b0;
    endproperty
    a_baud_zero: assert property (p_baud_zero) else $error("unimplemented bit read one");

    property p_idle_drop;
        pen && is_async && eng_in.rx_start && !wr_txc && !wr_rxc |=> !receive_idle_flag_ff;
    endproperty
    a_idle_drop: assert property (p_idle_drop) else $error("idle flag not cleared");

    property p_wake;
        eng_in.rx_edge && pen && is_async && baud_ff[serial_port_pkg::BAUD_WAKE] && !wr_baud
            |=> !baud_ff[serial_port_pkg::BAUD_WAKE] && wake_ff ##1 rx_irq;
    endproperty
    a_wake: assert property (p_wake) else $error("wake edge not handled");

    property p_shift_empty_flag;
        pen |=> shift_empty_flag_ff == $past(eng_in.shift_empty);
    endproperty
    a_shift_empty_flag: assert property (p_shift_empty_flag) else $error("shift empty flag wrong");
endmodule
`default_nettype wire

/* tb/eng_model.sv */
// far-side engine model: receive shifter, break timer and auto-baud timer
`timescale 1ns/1ps
`default_nettype none
module eng_model (
    input wire logic clk,
    input wire logic srst,
    input wire serial_port_pkg::port_cfg_t cfg,
    input wire logic inj,
    input wire serial_port_pkg::rx_char_t ch,
    input wire logic edge_req,
    input wire logic busy,
    input wire logic slow,
    output serial_port_pkg::eng_status_t st,
    output logic rx_busy
);
    int rcnt;
    int bcnt;
    int acnt;
    logic brk_q;
    logic abd_q;
    assign rx_busy = (rcnt != 0);
    always_ff @(posedge clk) begin
        st <= '0;
        st.shift_empty <= !busy;
        st.rx_edge <= edge_req;
        // character lines show the inverse outside a valid pulse, never a stale copy
        st.rx_char <= serial_port_pkg::rx_char_t'(~ch);
        brk_q <= cfg.send_break;
        abd_q <= cfg.autobaud_run;
        if (srst) begin
            rcnt <= 0;
            bcnt <= 0;
            acnt <= 0;
        end else begin
            if (inj) begin
                rcnt <= slow ? 12 : 3;
                st.rx_start <= 1'b1;
            end else if (rcnt != 0) begin
                rcnt <= rcnt - 1;
                st.rx_valid <= (rcnt == 1);
                if (rcnt == 1) st.rx_char <= ch;
            end
            // start on the rising edge only: the request bit lingers two cycles after done
            if (cfg.send_break && !brk_q) bcnt <= 4;
            else if (bcnt != 0) bcnt <= bcnt - 1;
            st.break_done <= (bcnt == 1);
            if (cfg.autobaud_run && !abd_q) acnt <= slow ? 40 : 4;
            else if (acnt != 0) acnt <= acnt - 1;
            st.abd_overflow <= (acnt == 20);
            st.abd_done <= (acnt == 1);
        end
    end
endmodule
`default_nettype wire

/* tb/test_serial_port_regs.sv */
// self-checking bench of the serial port register set
`timescale 1ns/1ps
`default_nettype none
module test_serial_port_regs;
    typedef struct packed {
        logic [31:0] e;
        logic [31:0] m;
    } exp_t;
    localparam logic [4:0] A_TX = serial_port_pkg::TXC_ADDR;
    localparam logic [4:0] A_RX = serial_port_pkg::RXC_ADDR;
    localparam logic [4:0] A_BD = serial_port_pkg::BAUD_ADDR;
    localparam logic [4:0] A_RD = serial_port_pkg::RXD_ADDR;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [serial_port_pkg::ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    serial_port_pkg::eng_status_t eng_in;
    serial_port_pkg::port_cfg_t cfg_out;
    logic rx_irq;
    logic inj = 1'b0;
    serial_port_pkg::rx_char_t ch = '0;
    logic edge_req = 1'b0;
    logic busy = 1'b0;
    logic slow = 1'b0;
    logic rx_busy;
    exp_t expq[$];
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 32'hca19466f;
    logic [7:0] w;
    logic [8:0] d2;

    always #10 clk = ~clk;

    serial_port_regs u_serial_port_regs (
        .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .eng_in(eng_in), .cfg_out(cfg_out), .rx_irq(rx_irq)
    );
    eng_model u_eng_model (
        .clk(clk), .srst(srst), .cfg(cfg_out), .inj(inj), .ch(ch), .edge_req(edge_req),
        .busy(busy), .slow(slow), .st(eng_in), .rx_busy(rx_busy)
    );

    // ************************************************************
    // checking and reporting
    // ************************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic fail(input string msg);
        err_total++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask
    task automatic cmp_rd(input logic [31:0] got, input exp_t x);
        n_checks++;
        if ((got & x.m) !== x.e) fail($sformatf("read %h want %h", got & x.m, x.e));
    endtask
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) fail({what, " wrong"});
    endtask
    // the read note is taken off the queue at the edge that completes the read
    always @(posedge clk) begin
        if (avs_read && !avs_waitrequest) begin
            if (expq.size() == 0) fail("read without note");
            else cmp_rd(avs_readdata, expq.pop_front());
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail("timeout");
            print_verdict();
        end
    end

    // ************************************************************
    // bus and line drivers
    // ************************************************************
    task automatic bus(input logic rd, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= {24'h0, d};
        @(posedge clk);
        while (avs_waitrequest) @(posedge clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b0, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
        expq.push_back({24'h0, e & m, 24'hffffff, m});
        bus(1'b1, a, 8'h00);
    endtask
    task automatic send(input logic [8:0] d, input logic fe);
        @(posedge clk);
        ch <= '{framing_error_flag: fe, data: d};
        inj <= 1'b1;
        @(posedge clk);
        inj <= 1'b0;
        if (slow) rd(A_BD, 8'h00, 8'h40);
        @(posedge clk);
        while (rx_busy) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(A_TX, 8'h02, 8'hff);
        rd(A_RX, 8'h00, 8'hff);
        rd(A_BD, 8'h40, 8'hff);
        rd(5'h10, 8'h00, 8'hff);
        $display("end reset");
        for (int i = 0; i < 4; i++) begin
            w = 8'($random(seed)) & 8'hfe;
            wr(A_BD, w);
            rd(A_BD, (w & 8'h1a) | 8'h40, 8'hff);
            repeat (3) @(posedge clk);
            cmp_bit(cfg_out.polarity, w[4], "polarity");
            cmp_bit(cfg_out.wide_gen, w[3], "wide");
        end
        wr(A_BD, 8'h00);
        $display("end baud control");
        wr(A_RX, 8'h80);
        for (int i = 0; i < 6; i++) begin
            w = 8'($random(seed)) & 8'hf7;
            wr(A_TX, w);
            rd(A_TX, (w & 8'hf5) | 8'h02, 8'hff);
            repeat (3) @(posedge clk);
            cmp_bit(cfg_out.port_enable, 1'b1, "pen");
            cmp_bit(cfg_out.sync_mode, w[4], "sync");
            cmp_bit(cfg_out.clock_master, w[4] & w[7], "master");
            cmp_bit(cfg_out.tx_enable, w[5], "transmit_enable_bit");
            cmp_bit(cfg_out.tx_nine, w[6], "tx9");
            cmp_bit(cfg_out.tx_ninth, w[0], "transmit_ninth_bit");
            cmp_bit(cfg_out.high_baud, w[2] & !w[4], "high");
        end
        busy <= 1'b1;
        repeat (2) @(posedge clk);
        rd(A_TX, 8'h00, 8'h02);
        busy <= 1'b0;
        wr(A_TX, 8'h00);
        $display("end transmit control");
        wr(A_RX, 8'hd0);
        repeat (3) @(posedge clk);
        cmp_bit(cfg_out.rx_enable, 1'b1, "rxen");
        cmp_bit(cfg_out.rx_nine, 1'b1, "rx9");
        slow <= 1'b1;
        send(9'h1c3, 1'b1);
        slow <= 1'b0;
        cmp_bit(rx_irq, 1'b1, "irq");
        rd(A_RX, 8'hd5, 8'hff);
        rd(A_RD, 8'hc3, 8'hff);
        rd(A_BD, 8'h40, 8'h40);
        repeat (2) @(posedge clk);
        cmp_bit(rx_irq, 1'b0, "irq");
        $display("end receive");
        d2 = 9'($random(seed));
        send(9'h1a5, 1'b1);
        send(d2, 1'b0);
        send(9'h0ee, 1'b0);
        rd(A_RX, 8'hd7, 8'hff);
        cmp_bit(cfg_out.rx_enable, 1'b0, "rxen");
        wr(A_RX, 8'hc0);
        rd(A_RX, 8'hc5, 8'hff);
        rd(A_RD, 8'ha5, 8'hff);
        rd(A_RX, 8'hc0 | {7'h0, d2[8]}, 8'hff);
        rd(A_RD, d2[7:0], 8'hff);
        $display("end overrun");
        wr(A_RX, 8'hd0);
        send(9'h0ff, 1'b1);
        wr(A_RX, 8'h50);
        rd(A_RX, 8'h50, 8'hff);
        repeat (2) @(posedge clk);
        cmp_bit(rx_irq, 1'b0, "irq");
        cmp_bit(cfg_out.port_enable, 1'b0, "pen");
        $display("end port disable");
        wr(A_RX, 8'hd8);
        send(9'h033, 1'b0);
        cmp_bit(rx_irq, 1'b0, "irq");
        send(9'h155, 1'b0);
        rd(A_RX, 8'hd9, 8'hff);
        rd(A_RD, 8'h55, 8'hff);
        wr(A_RX, 8'h98);
        send(9'h033, 1'b0);
        rd(A_RD, 8'h33, 8'hff);
        $display("end address detect");
        wr(A_TX, 8'h28);
        repeat (3) @(posedge clk);
        cmp_bit(cfg_out.send_break, 1'b1, "brk");
        repeat (7) @(posedge clk);
        rd(A_TX, 8'h22, 8'hff);
        cmp_bit(cfg_out.send_break, 1'b0, "brk");
        slow <= 1'b1;
        wr(A_BD, 8'h01);
        repeat (10) @(posedge clk);
        cmp_bit(cfg_out.autobaud_run, 1'b1, "abd");
        rd(A_BD, 8'h41, 8'hff);
        repeat (40) @(posedge clk);
        rd(A_BD, 8'hc0, 8'hff);
        cmp_bit(cfg_out.autobaud_run, 1'b0, "abd");
        slow <= 1'b0;
        $display("end break and auto-baud");
        wr(A_BD, 8'h02);
        repeat (3) @(posedge clk);
        cmp_bit(cfg_out.wake_wait, 1'b1, "wake");
        edge_req <= 1'b1;
        @(posedge clk);
        edge_req <= 1'b0;
        repeat (3) @(posedge clk);
        cmp_bit(rx_irq, 1'b1, "irq");
        cmp_bit(cfg_out.wake_wait, 1'b0, "wake");
        rd(A_BD, 8'hc0, 8'hff);
        rd(A_RD, 8'h00, 8'hff);
        repeat (2) @(posedge clk);
        cmp_bit(rx_irq, 1'b0, "irq");
        $display("end wake");
        wr(A_TX, 8'h90);
        wr(A_RX, 8'ha0);
        send(9'h011, 1'b0);
        rd(A_RX, 8'h80, 8'hf8);
        rd(A_RD, 8'h11, 8'hff);
        $display("end single receive");
        print_verdict();
    end
endmodule
`default_nettype wire
